/* hw/flash_poll_ctrl.sv */
/*
  Host-side controller for a parallel flash that reports program and
  erase progress through status bits on its data bus. Software issues
  single reads, writes, toggle polls and erase timer checks over APB.
  Assumes the flash pins are asynchronous to pclk; all inputs from the
  flash pass two flip-flops before use. Data pins are two-way.
*/
`timescale 1ns/1ns
module flash_poll_ctrl
  import flash_poll_pkg::*;
#(
  parameter int ADDR_W = 19
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic flash_ready_busy
);

  // Refuse address widths that the address register cannot hold.
  if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_width
    $error("ADDR_W must lie between 1 and 32");
  end

  // Sequencer states for one flash cycle or a toggle poll.
  typedef enum logic [3:0] {
    IDLE, RD_STROBE, RD_GAP, WR_STROBE, WR_GAP, EVAL, RST_STROBE, RST_GAP
  } seq_state_t;

  seq_state_t state_q, state_d;
  // Software-written target address and write data.
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wdata_q;
  // Operation being run and last completed read byte.
  logic [1:0] op_q;
  logic [7:0] rdata_q;
  // Bytes from the current poll: first and second read, and the read count.
  logic [7:0] first_q, second_q;
  logic [1:0] nreads_q;
  // Status flags reported to software.
  logic busy_q, done_q, fail_q, active_q, timer_q, erasing_q, susp_q;
  logic [CNT_W-1:0] cnt_q;
  // Two-stage synchronisers for the flash inputs.
  logic [7:0] dq_meta_q, dq_sync_q;
  logic rb_meta_q, rb_sync_q;

  // Synchronise the asynchronous flash pins before any logic reads them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_meta_q <= 8'h00;
      dq_sync_q <= 8'h00;
      rb_meta_q <= 1'b1;
      rb_sync_q <= 1'b1;
    end else begin
      dq_meta_q <= flash_dq_in;
      dq_sync_q <= dq_meta_q;
      rb_meta_q <= flash_ready_busy;
      rb_sync_q <= rb_meta_q;
    end
  end

  // APB decode: access phase write and start strobe.
  // A transfer takes effect only at the edge where pready is seen high.
  wire apb_acc = psel && penable && pready;
  wire apb_wr = apb_acc && pwrite;
  wire go_wr = apb_wr && (paddr == CTRL_OFF) && pwdata[CTRL_GO_BIT] && !busy_q;
  wire unmapped = (paddr != CTRL_OFF) && (paddr != ADDR_OFF) && (paddr != WDATA_OFF)
    && (paddr != STATUS_OFF) && (paddr != RDATA_OFF);

  // Toggle comparisons between the stored reads of one poll.
  wire op_tog12 = first_q[OP_TOGGLE_BIT] != second_q[OP_TOGGLE_BIT];
  // The third byte is held in rdata_q; the live bus is released by then.
  wire op_tog23 = second_q[OP_TOGGLE_BIT] != rdata_q[OP_TOGGLE_BIT];
  wire er_tog12 = first_q[ERASE_TOGGLE_BIT] != second_q[ERASE_TOGGLE_BIT];
  wire strobe_end = cnt_q == CNT_W'(STROBE_CYC - 1);
  wire gap_end = cnt_q == CNT_W'(RECOVER_CYC - 1);

  // Next state of the flash cycle sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (go_wr) begin
          state_d = (pwdata[CTRL_OP_LSB +: 2] == OP_WRITE) ? WR_STROBE : RD_STROBE;
        end
      end
      RD_STROBE: begin
        if (strobe_end) begin
          state_d = (op_q == OP_READ) ? IDLE : RD_GAP;
        end
      end
      RD_GAP: begin
        if (gap_end) begin
          // A quiet third read ends the poll as a success; a failed one is diverted below.
          state_d = (nreads_q == 2'd1) ? RD_STROBE : (nreads_q == 2'd3) ? IDLE : EVAL;
        end
      end
      WR_STROBE: begin
        if (strobe_end) begin
          state_d = WR_GAP;
        end
      end
      WR_GAP: begin
        if (gap_end) begin
          state_d = IDLE;
        end
      end
      EVAL: begin
        // A third read is taken when toggling persists with timeout high.
        if (op_q == OP_POLL && op_tog12 && second_q[TIMEOUT_BIT] && nreads_q == 2'd2) begin
          state_d = RD_STROBE;
        end else begin
          state_d = IDLE;
        end
      end
      RST_STROBE: begin
        if (strobe_end) begin
          state_d = RST_GAP;
        end
      end
      RST_GAP: begin
        if (gap_end) begin
          state_d = IDLE;
        end
      end
      default: state_d = IDLE;
    endcase
  end

  // Third read still toggling: failed operation needs the reset command.
  wire third_fail = (state_q == RD_GAP) && gap_end && nreads_q == 2'd3 && op_tog23;
  // State actually entered next; the pins follow it so the reset strobe is full length.
  seq_state_t state_n;
  assign state_n = third_fail ? RST_STROBE : state_d;

  // Sequencer state and strobe-phase counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_n;
      cnt_q <= (state_n != state_q) ? '0 : cnt_q + 1'b1;
    end
  end

  // Software registers, read counting and capture of status bytes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
      wdata_q <= 8'h00;
      op_q <= OP_READ;
      rdata_q <= 8'h00;
      first_q <= 8'h00;
      second_q <= 8'h00;
      nreads_q <= 2'd0;
    end else begin
      if (apb_wr && paddr == ADDR_OFF && !busy_q) begin
        addr_q <= pwdata[ADDR_W-1:0];
      end
      if (apb_wr && paddr == WDATA_OFF && !busy_q) begin
        wdata_q <= pwdata[7:0];
      end
      if (go_wr) begin
        op_q <= pwdata[CTRL_OP_LSB +: 2];
        nreads_q <= 2'd0;
      end
      // Sample the data bus at the end of each read strobe.
      if (state_q == RD_STROBE && strobe_end) begin
        rdata_q <= dq_sync_q;
        nreads_q <= nreads_q + 2'd1;
        if (nreads_q == 2'd0) begin
          first_q <= dq_sync_q;
        end else if (nreads_q == 2'd1) begin
          second_q <= dq_sync_q;
        end
      end
    end
  end

  // Outcome flags; a new start sets busy and clears done and fail, completion clears busy and sets done.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      active_q <= 1'b0;
      timer_q <= 1'b0;
      erasing_q <= 1'b0;
      susp_q <= 1'b0;
    end else begin
      if (go_wr) begin
        busy_q <= 1'b1;
        done_q <= 1'b0;
        fail_q <= 1'b0;
      end else if (state_q != IDLE && state_n == IDLE) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
      if (state_q == EVAL) begin
        // Unchanged toggle means the operation finished.
        active_q <= op_tog12;
        // Optional check: software that paces its erases may never ask for it.
        timer_q <= second_q[ERASE_TIMER_BIT];
        erasing_q <= op_tog12 && er_tog12;
        susp_q <= !op_tog12 && er_tog12;
      end
      if (third_fail) begin
        fail_q <= 1'b1;
        active_q <= 1'b0;
      end else if (state_q == RD_GAP && gap_end && nreads_q == 2'd3) begin
        active_q <= 1'b0;
      end
    end
  end

  // Flash pin drive; strobes are active low and registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr <= '0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= 8'h00;
      flash_dq_oe_n <= 1'b1;
    end else begin
      flash_addr <= addr_q;
      flash_ce_n <= !(state_n == RD_STROBE || state_n == WR_STROBE || state_n == RST_STROBE);
      flash_oe_n <= state_n != RD_STROBE;
      flash_we_n <= !(state_n == WR_STROBE || state_n == RST_STROBE);
      flash_dq_out <= (state_n == RST_STROBE || state_n == RST_GAP) ? RESET_CMD : wdata_q;
      flash_dq_oe_n <= !(state_n == WR_STROBE || state_n == RST_STROBE);
    end
  end

  // Read data mux for the APB slave.
  wire [31:0] status_word = {24'h0, susp_q, erasing_q, rb_sync_q, timer_q,
    active_q, fail_q, done_q, busy_q};
  wire [31:0] rd_mux = (paddr == CTRL_OFF) ? {29'h0, op_q, 1'b0} :
    (paddr == ADDR_OFF) ? 32'(addr_q) :
    (paddr == WDATA_OFF) ? {24'h0, wdata_q} :
    (paddr == STATUS_OFF) ? status_word :
    (paddr == RDATA_OFF) ? {24'h0, rdata_q} : 32'h0;

  // APB answer: no wait state, so pready rises in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // Reset command goes out only after a confirmed third toggling read.
  a_reset_after_fail: assert property (@(posedge pclk) disable iff (!presetn)
    third_fail |=> state_q == RST_STROBE) else $error("reset command not issued");
  // Evaluation is reached only after at least two poll reads.
  a_two_reads: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == EVAL) |-> nreads_q >= 2'd2) else $error("poll judged on one read");
  // Active flag clears when no toggling seen on the evaluated pair.
  a_finish_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == EVAL && !op_tog12) |=> !active_q) else $error("active after stop");
  // Output enable and write strobe never overlap.
  a_strobe_excl: assert property (@(posedge pclk) disable iff (!presetn)
    !(!flash_oe_n && !flash_we_n)) else $error("oe and we both low");
  // Timeout with toggling yields a third read.
  a_third_read: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == EVAL && op_q == OP_POLL && op_tog12 && second_q[TIMEOUT_BIT]
     && nreads_q == 2'd2) |=> state_q == RD_STROBE) else $error("no recheck");
  // A start restarts the read count.
  a_restart: assert property (@(posedge pclk) disable iff (!presetn)
    go_wr |=> nreads_q == 2'd0) else $error("poll not restarted");
  // Timer flag captured from the second read.
  a_timer_cap: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == EVAL |=> timer_q == $past(second_q[ERASE_TIMER_BIT]))
    else $error("timer flag lost");
  // Reset command drives the data bus.
  a_reset_data: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == RST_STROBE |-> !flash_dq_oe_n && flash_dq_out == RESET_CMD)
    else $error("reset data wrong");
  c_poll_done: cover property (@(posedge pclk) state_q == EVAL && !op_tog12);
  c_poll_fail: cover property (@(posedge pclk) third_fail);
  c_write: cover property (@(posedge pclk) state_q == WR_STROBE);
endmodule

/* hw/flash_poll_pkg.sv */
/*
  Package for the flash status polling controller: register map of the
  controller's own APB registers, field positions, status bit positions
  on the flash data bus and bus timing counts.
  Assumes a 100 MHz pclk and an external parallel flash whose busy bank
  returns write status on its data bits.
*/
package flash_poll_pkg;
  // Controller register offsets (byte addresses).
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ADDR_OFF = 8'h04;
  localparam logic [7:0] WDATA_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] RDATA_OFF = 8'h10;
  // Control register fields.
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  // Commands written to the control register operation field.
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_POLL = 2'h2;
  localparam logic [1:0] OP_ERASE_CHECK = 2'h3;
  // Status register fields.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_ACTIVE_BIT = 3;
  localparam int ST_TIMER_BIT = 4;
  localparam int ST_RB_BIT = 5;
  localparam int ST_ERASING_BIT = 6;
  localparam int ST_SUSP_BIT = 7;
  // Status bit positions on the flash data bus.
  localparam int POLLING_BIT = 7;
  localparam int OP_TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int ERASE_TIMER_BIT = 3;
  localparam int ERASE_TOGGLE_BIT = 2;
  // Reset command data written to any address.
  localparam logic [7:0] RESET_CMD = 8'hf0;
  // Strobe timing: times in ns and derived cycle counts at 10 ns.
  localparam int CLK_NS = 10;
  localparam int STROBE_NS = 70;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_NS = 30;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
endpackage

/* testbench/flash_dev_model.sv */
/*
  Behavioural model of a parallel flash bank that reports write status on its data bits.
  Assumes the bench sets the operating mode through a port and holds it steady during a poll.
*/
`timescale 1ns/1ns
module flash_dev_model (
  input wire logic [18:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic [2:0] mode,
  output logic [7:0] flash_dq_in,
  output logic flash_ready_busy,
  output logic [7:0] last_wr
);
  // Modes: 0 ready, 1 erasing, 2 acceptance window, 3 erase suspended, 4 timed out,
  // 5 timeout flag high but the operation toggle stops from the third read on.
  logic t6 = 1'b0;
  logic t2 = 1'b0;
  logic [1:0] nrd = 2'd0;
  wire rd_n = flash_ce_n | flash_oe_n;
  wire wr_n = flash_ce_n | flash_we_n;
  wire late = (mode == 3'd4) || (mode == 3'd5);
  wire busy = (mode == 3'd1) || (mode == 3'd2) || late;
  wire in_bank = (flash_addr[18:16] == 3'h0);
  wire in_sector = (flash_addr[18:12] == 7'h00);
  wire [7:0] stat;
  wire [7:0] val;
  // Status byte: polling, operation toggle, timeout, timer and erase toggle bits.
  assign stat = {mode == 3'd3, t6, late, 1'b0, (mode == 3'd1) || late,
    t2, 2'b00};
  assign val = (mode != 3'd0 && in_bank) ? stat : 8'ha5;
  // A released bus shows the inverse of the last value, never a stale copy.
  assign flash_dq_in = rd_n ? ~val : val;
  assign flash_ready_busy = !busy;
  // A new mode restarts the count of reads in the bank.
  always @(mode) begin
    nrd <= 2'd0;
  end
  // Each read start in the bank flips the operation toggle while busy (mode 5: first two only) and, outside mode 0, the erase toggle in the first sector.
  always @(negedge rd_n) begin
    if (in_bank && nrd != 2'd3) begin
      nrd <= nrd + 2'd1;
    end
    if (busy && in_bank && !(mode == 3'd5 && nrd >= 2'd2)) begin
      t6 <= ~t6;
    end
    if (mode != 3'd0 && in_bank && in_sector) begin
      t2 <= ~t2;
    end
  end
  // Written data is latched at the end of the write strobe; mode 1 latches only 8'hb0.
  initial last_wr = 8'h00;
  always @(posedge wr_n) begin
    if (mode != 3'd1 || flash_dq_out == 8'hb0) begin
      last_wr <= flash_dq_out;
    end
  end
endmodule

/* testbench/tb_top.sv */
/*
  Self-checking bench of the flash polling controller: APB master, flash model, scenarios.
  Assumes the register map and status fields of the controller package.
*/
`timescale 1ns/1ns
`define CHK(a, e) chk(32'(a), 32'(e))
module tb_top;
  import flash_poll_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic pready, pslverr, err, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
  logic flash_ready_busy;
  logic [18:0] flash_addr;
  logic [7:0] flash_dq_in, flash_dq_out, last_wr;
  logic [2:0] mode = 3'd0;
  int err_total = 0, n_compared = 0;
  flash_poll_ctrl i_flash_poll_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ready_busy(flash_ready_busy));
  flash_dev_model i_flash_dev_model (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n), .mode(mode), .flash_dq_in(flash_dq_in),
    .flash_ready_busy(flash_ready_busy), .last_wr(last_wr));
  // Clock at 100 MHz.
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Compares a value with its expectation and counts the outcome.
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    n_compared++;
    if (a !== e) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, a, e);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sets the flash mode, starts one operation and waits for the done flag.
  task automatic run(input logic [2:0] m, input logic [1:0] op, input logic [18:0] a);
    int n;
    mode <= m;
    repeat (4) @(posedge pclk);
    apb(1'b1, ADDR_OFF, {13'h0, a});
    apb(1'b1, CTRL_OFF, {29'h0, op, 1'b1});
    n = 0;
    do begin
      apb(1'b0, STATUS_OFF, 32'h0);
      n++;
    end while (rd[ST_DONE_BIT] !== 1'b1 && n < 200);
    if (rd[ST_DONE_BIT] !== 1'b1) begin
      err_total++;
      end_sim();
    end
    `CHK(rd[ST_BUSY_BIT], 1'b0);
    st = rd;
  endtask
  // Bank ready: toggle bits stand still, the poll ends clean.
  task automatic t_ready();
    run(3'd0, OP_POLL, 19'h0);
    `CHK({st[ST_ACTIVE_BIT], st[ST_FAIL_BIT], st[ST_RB_BIT]}, 3'b001);
    $display("test ready done");
  endtask
  // Erasing sector: both toggles move, timer flag high, ready-busy low.
  task automatic t_erase();
    run(3'd1, OP_POLL, 19'h00010);
    `CHK({st[ST_ACTIVE_BIT], st[ST_FAIL_BIT], st[ST_ERASING_BIT]}, 3'b101);
    `CHK({st[ST_TIMER_BIT], st[ST_RB_BIT]}, 2'b10);
    run(3'd1, OP_POLL, 19'h01000);
    `CHK(st[ST_ERASING_BIT], 1'b0);
    $display("test erase done");
  endtask
  // Acceptance window: timer flag still low.
  task automatic t_window();
    run(3'd2, OP_ERASE_CHECK, 19'h0);
    `CHK({st[ST_ACTIVE_BIT], st[ST_TIMER_BIT]}, 2'b10);
    $display("test window done");
  endtask
  // Timed out: toggling persists, fail is flagged and the reset command goes out.
  task automatic t_timeout();
    run(3'd4, OP_POLL, 19'h0);
    `CHK(st[ST_FAIL_BIT], 1'b1);
    `CHK(last_wr, RESET_CMD);
    run(3'd5, OP_POLL, 19'h0);
    `CHK({st[ST_ACTIVE_BIT], st[ST_FAIL_BIT]}, 2'b00);
    $display("test timeout done");
  endtask
  // Suspended sector: only the erase toggle moves.
  task automatic t_suspend();
    run(3'd3, OP_POLL, 19'h0);
    `CHK({st[ST_ACTIVE_BIT], st[ST_SUSP_BIT], st[ST_RB_BIT]}, 3'b011);
    $display("test suspend done");
  endtask
  // Other bank reads array data; a plain write reaches the flash.
  task automatic t_bank_write();
    run(3'd1, OP_READ, 19'h10000);
    apb(1'b0, RDATA_OFF, 32'h0);
    `CHK(rd[7:0], 8'ha5);
    apb(1'b1, WDATA_OFF, 32'h3c);
    run(3'd0, OP_WRITE, 19'h00123);
    `CHK(last_wr, 8'h3c);
    apb(1'b0, 8'h20, 32'h0);
    `CHK(err, 1'b1);
    `CHK(rd, 32'h0);
    $display("test bank and write done");
  endtask
  // Reset for 6 cycles, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_ready();
    t_erase();
    t_window();
    t_timeout();
    t_suspend();
    t_bank_write();
    end_sim();
  end
endmodule
